// file: time_of_day_counter.sv
// time-of-day counter: two chained counters, preload, snapshot, AXI4-Lite
// assumes reference ticks arrive as one-cycle enables synchronous to sys_clk
`default_nettype none

// Contract
// - reference tick taken from any one divider output, chosen by a register
// - time clock period is clock divider setting plus one reference ticks
// - clock divider settings accepted over their whole six-bit range
// - time pulse period is pulse divider setting plus one time clock ticks
// - readable counts refresh every microsecond while counting goes on
// - counting runs only while the enable bit is one
// - reading the snapshot register freezes the readable counts
// - frozen time clock and time pulse counts come from one instant
// - time clock count read in readback bits 82 down to 31
// - time pulse count read in readback bits 30 down to 0
// - preload buffer bits 82 down to 31 hold the new time clock count
// - preload buffer bits 30 down to 0 hold the new time pulse count
// - arm bit 1 makes the time clock counter join the next load
// - arm bit 0 makes the time pulse counter join the next load
// - trigger waits for next time pulse edge, then loads the armed counters together
module time_of_day_counter
    import tod_pkg::*;
#(
    parameter int NUM_SOURCES = 3,   // selectable divider outputs
    parameter int ADDR_W      = 16   // bus byte address width
) (
    input  wire logic              sys_clk,   // 20 MHz system clock
    input  wire logic              nrst,      // async reset, active low
    input  wire logic [NUM_SOURCES-1:0] fractional_divider_output, // ticks
    output var  logic              time_clock_tick,  // one per tclk period
    output var  logic              time_pulse_tick,  // one per pulse period
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire logic [2:0]        s_axi_awprot,   // unused protection
    input  wire logic              s_axi_awvalid,  // write address valid
    output var  logic              s_axi_awready,  // write address ready
    input  wire logic [31:0]       s_axi_wdata,    // write data
    input  wire logic [3:0]        s_axi_wstrb,    // byte enables
    input  wire logic              s_axi_wvalid,   // write data valid
    output var  logic              s_axi_wready,   // write data ready
    output var  logic [1:0]        s_axi_bresp,    // write response
    output var  logic              s_axi_bvalid,   // write response valid
    input  wire logic              s_axi_bready,   // write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire logic [2:0]        s_axi_arprot,   // unused protection
    input  wire logic              s_axi_arvalid,  // read address valid
    output var  logic              s_axi_arready,  // read address ready
    output var  logic [31:0]       s_axi_rdata,    // read data
    output var  logic [1:0]        s_axi_rresp,    // read response
    output var  logic              s_axi_rvalid,   // read data valid
    input  wire logic              s_axi_rready    // read data ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    // word index from a byte address
    function automatic logic [13:0] word_idx(input logic [ADDR_W-1:0] a);
        return a[15:2];
    endfunction : word_idx

    // software-visible configuration
    logic [CLK_DIV_W-1:0]   clk_div;
    logic [PULSE_DIV_W-1:0] pulse_div;
    logic [SEL_W-1:0]       ref_select;
    logic                   count_en;
    logic [95:0]            preload_buf;
    logic [1:0]             arm;
    logic                   load_pending;

    // live counters and prescalers
    logic [CLK_DIV_W-1:0]   ref_cnt;
    logic [PULSE_DIV_W-1:0] tclk_cnt;
    count_pair_t            live;
    count_pair_t            shown;
    logic                   frozen;
    logic [REFRESH_W-1:0]   refresh_cnt;

    // bus holding state
    logic [13:0]            aw_idx;
    logic                   aw_full;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   w_full;
    logic [31:0]            old_word;
    logic [31:0]            new_word;

    logic                   wr_fire;
    logic                   rd_fire;
    logic [13:0]            rd_idx;
    logic                   ref_tick;
    logic                   tclk_edge;
    logic                   tpulse_edge;
    logic                   refresh_tick;
    logic                   trig_write;

    // a write is committed when address and data are both held
    assign wr_fire = aw_full && w_full && !s_axi_bvalid;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx  = word_idx(s_axi_araddr);
    assign trig_write = wr_fire && (aw_idx == IDX_TRIGGER) && w_strb[0]
                        && w_data[TRIGGER_BIT];

    // stored value of the addressed register, merged with the strobes
    always_comb begin
        old_word = 32'h00000000;
        case (aw_idx)
            IDX_CLK_DIV:    old_word = 32'(clk_div);
            IDX_REF_SELECT: old_word = 32'(ref_select);
            IDX_PULSE_DIV:  old_word = 32'(pulse_div);
            IDX_ENABLE:     old_word = 32'(count_en);
            IDX_ARM:        old_word = 32'(arm);
            default:        old_word = 32'h00000000;
        endcase
    end
    assign new_word = merge_strb(old_word, w_data, w_strb);

    always_comb begin
        ref_tick = 1'b0;
        if (int'(ref_select) < NUM_SOURCES) begin
            ref_tick = fractional_divider_output[ref_select];
        end
    end

    // time clock edge after clk_div+1 ticks
    assign tclk_edge = count_en && ref_tick && (ref_cnt == clk_div);
    // pulse edge after pulse_div+1 tclk edges
    assign tpulse_edge = tclk_edge && (tclk_cnt == pulse_div);
    assign refresh_tick =
        (refresh_cnt == REFRESH_W'(REFRESH_CYCLES - 1));

    // write address channel
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_full       <= 1'b0;
            aw_idx        <= 14'h0000;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full       <= 1'b1;
            aw_idx        <= word_idx(s_axi_awaddr);
            s_axi_awready <= 1'b0;
        end else if (wr_fire) begin
            aw_full       <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            w_full       <= 1'b0;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (wr_fire) begin
            w_full       <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // write response, error on unmapped index
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx)
                IDX_CLK_DIV, IDX_REF_SELECT, IDX_PULSE_DIV, IDX_ENABLE,
                IDX_PRELOAD_W0, IDX_PRELOAD_W1, IDX_PRELOAD_W2,
                IDX_ARM, IDX_TRIGGER: s_axi_bresp <= RESP_OKAY;
                default:              s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clk_div     <= RST_CLK_DIV;
            pulse_div   <= RST_PULSE_DIV;
            ref_select  <= RST_SELECT;
            count_en    <= 1'b0;
            preload_buf <= 96'h0;
            arm         <= 2'h0;
        end else if (wr_fire) begin
            case (aw_idx)
                IDX_CLK_DIV:    clk_div    <= new_word[CLK_DIV_W-1:0];
                IDX_REF_SELECT: ref_select <= new_word[SEL_W-1:0];
                IDX_PULSE_DIV:  pulse_div  <= new_word[PULSE_DIV_W-1:0];
                IDX_ENABLE:     count_en   <= new_word[ENABLE_BIT];
                IDX_PRELOAD_W0: preload_buf[31:0] <=
                    merge_strb(preload_buf[31:0], w_data, w_strb);
                IDX_PRELOAD_W1: preload_buf[63:32] <=
                    merge_strb(preload_buf[63:32], w_data, w_strb);
                IDX_PRELOAD_W2: preload_buf[95:64] <=
                    merge_strb(preload_buf[95:64], w_data, w_strb);
                IDX_ARM:        arm        <= new_word[1:0];
                default: ;
            endcase
        end
    end

    // pending trigger; a new write wins over the clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            load_pending <= 1'b0;
        end else if (trig_write) begin
            load_pending <= 1'b1;
        end else if (tpulse_edge) begin
            // clear once the load is done
            load_pending <= 1'b0;
        end
    end

    // reference tick prescaler
    // lowering the divider below the running count costs one full wrap
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ref_cnt <= '0;
        end else if (count_en && ref_tick) begin
            ref_cnt <= tclk_edge ? '0 : ref_cnt + 1'b1;
        end
    end

    // time clock prescaler toward the pulse edge
    // same wrap hazard when the pulse divider is lowered mid-count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tclk_cnt <= '0;
        end else if (tclk_edge) begin
            tclk_cnt <= tpulse_edge ? '0 : tclk_cnt + 1'b1;
        end
    end

    // live counts; armed counters take the buffer at the pulse edge
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            live <= '0;
        end else begin
            if (tpulse_edge && load_pending && arm[ARM_TCLK_BIT]) begin
                live.tclk <= preload_buf[82:31];
            end else if (tclk_edge) begin
                live.tclk <= live.tclk + 1'b1;
            end
            if (tpulse_edge && load_pending && arm[ARM_TPULSE_BIT]) begin
                live.tpulse <= preload_buf[30:0];
            end else if (tpulse_edge) begin
                live.tpulse <= live.tpulse + 1'b1;
            end
        end
    end

    // microsecond refresh divider
    // free-running, so the refresh grid ignores the enable bit
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            refresh_cnt <= '0;
        end else if (refresh_tick) begin
            refresh_cnt <= '0;
        end else begin
            refresh_cnt <= refresh_cnt + 1'b1;
        end
    end

    // freeze flag: snapshot read sets, final readback word clears
    // word two must be read last, or the freeze ends before the other words are read
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            frozen <= 1'b0;
        end else if (rd_fire && rd_idx == IDX_SNAP_REQ) begin
            frozen <= 1'b1;
        end else if (rd_fire && rd_idx == IDX_READBACK_W2) begin
            frozen <= 1'b0;
        end
    end

    // readable copy of both counts, taken as one struct
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            shown <= '0;
        end else if (rd_fire && rd_idx == IDX_SNAP_REQ) begin
            // both counts from the same cycle
            shown <= live;
        end else if (refresh_tick && !frozen) begin
            shown <= live;
        end
    end

    // read channel with registered data
    // rvalid follows the taken address by one cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (rd_idx)
                IDX_CLK_DIV:    s_axi_rdata <= 32'(clk_div);
                IDX_REF_SELECT: s_axi_rdata <= 32'(ref_select);
                IDX_PULSE_DIV:  s_axi_rdata <= 32'(pulse_div);
                IDX_ENABLE:     s_axi_rdata <= 32'(count_en);
                IDX_PRELOAD_W0: s_axi_rdata <= preload_buf[31:0];
                IDX_PRELOAD_W1: s_axi_rdata <= preload_buf[63:32];
                IDX_PRELOAD_W2: s_axi_rdata <= preload_buf[95:64];
                IDX_ARM:        s_axi_rdata <= 32'(arm);
                IDX_TRIGGER:    s_axi_rdata <= 32'(load_pending);
                IDX_SNAP_REQ:   s_axi_rdata <= 32'(frozen);
                // tclk above tpulse in 83 bits
                IDX_READBACK_W0: s_axi_rdata <= shown[31:0];
                IDX_READBACK_W1: s_axi_rdata <= shown[63:32];
                IDX_READBACK_W2: s_axi_rdata <= 32'(shown[82:64]);
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // registered tick outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            time_clock_tick <= 1'b0;
            time_pulse_tick <= 1'b0;
        end else begin
            time_clock_tick <= tclk_edge;
            time_pulse_tick <= tpulse_edge;
        end
    end

endmodule : time_of_day_counter

`default_nettype wire

// file: tod_pkg.sv
// time-of-day counter: register map, field layout, timing constants, types
// assumes one 20 MHz system clock and a 32-bit AXI4-Lite register bus
`default_nettype none

package tod_pkg;
    timeunit 1ns;
    timeprecision 100ps;

    // register indices; byte address is four times the index
    localparam logic [13:0] IDX_CLK_DIV      = 14'h0a00;
    localparam logic [13:0] IDX_REF_SELECT   = 14'h0a01;
    localparam logic [13:0] IDX_PULSE_DIV    = 14'h0a04;
    localparam logic [13:0] IDX_ENABLE       = 14'h0a0a;
    localparam logic [13:0] IDX_PRELOAD_W0   = 14'h0a10;
    localparam logic [13:0] IDX_PRELOAD_W1   = 14'h0a11;
    localparam logic [13:0] IDX_PRELOAD_W2   = 14'h0a12;
    localparam logic [13:0] IDX_ARM          = 14'h0a20;
    localparam logic [13:0] IDX_TRIGGER      = 14'h0a21;
    localparam logic [13:0] IDX_SNAP_REQ     = 14'h0a5f;
    localparam logic [13:0] IDX_READBACK_W0  = 14'h0a60;
    localparam logic [13:0] IDX_READBACK_W1  = 14'h0a61;
    localparam logic [13:0] IDX_READBACK_W2  = 14'h0a62;

    // field widths and positions
    localparam int CLK_DIV_W   = 6;
    localparam int PULSE_DIV_W = 31;
    localparam int TCLK_W      = 52;
    localparam int TPULSE_W    = 31;
    localparam int COUNT_W     = 83;
    localparam int SEL_W       = 2;
    localparam int ARM_TCLK_BIT   = 1;
    localparam int ARM_TPULSE_BIT = 0;
    localparam int ENABLE_BIT     = 0;
    localparam int TRIGGER_BIT    = 0;
    localparam int SNAP_BIT       = 0;

    // reset values
    localparam logic [CLK_DIV_W-1:0]   RST_CLK_DIV   = 6'h00;
    localparam logic [PULSE_DIV_W-1:0] RST_PULSE_DIV = 31'h00000000;
    localparam logic [SEL_W-1:0]       RST_SELECT    = 2'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing: readable counts refresh every microsecond
    localparam int CLK_PERIOD_NS   = 50;
    localparam int REFRESH_NS      = 1000;
    localparam int REFRESH_CYCLES  = REFRESH_NS / CLK_PERIOD_NS;
    localparam int REFRESH_W       = 5;

    // both counts travel together so a snapshot is always one instant
    typedef struct packed {
        logic [TCLK_W-1:0]   tclk;
        logic [TPULSE_W-1:0] tpulse;
    } count_pair_t;

endpackage : tod_pkg

`default_nettype wire

// file: tod_properties.sv
// checker for the time-of-day counter: bus answers and tick outputs
// assumes it is bound onto time_of_day_counter, one clock, async reset
`default_nettype none

module tod_properties
    import tod_pkg::*;
#(
    parameter int NUM_SOURCES = 3,  // selectable divider outputs
    parameter int ADDR_W      = 16  // bus byte address width
) (
    input wire logic                   sys_clk,         // clock
    input wire logic                   nrst,            // reset, active low
    input wire logic [NUM_SOURCES-1:0] fractional_divider_output, // refs
    input wire logic                   time_clock_tick, // clock tick
    input wire logic                   time_pulse_tick, // pulse tick
    input wire logic                   s_axi_awvalid,   // aw valid
    input wire logic                   s_axi_awready,   // aw ready
    input wire logic                   s_axi_wvalid,    // w valid
    input wire logic                   s_axi_wready,    // w ready
    input wire logic                   s_axi_bvalid,    // b valid
    input wire logic                   s_axi_bready,    // b ready
    input wire logic                   s_axi_arvalid,   // ar valid
    input wire logic                   s_axi_arready,   // ar ready
    input wire logic                   s_axi_rvalid,    // r valid
    input wire logic [31:0]            s_axi_rdata,     // read data
    input wire logic [1:0]             s_axi_rresp      // read response
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // answers arrive at the figures of the bus timing
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_read_busy: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_ready_back: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write channel not released");
    a_error_data: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    // chained counters: pulses only at clock edges, edges need a tick
    a_pulse_on_clock: assert property (
        time_pulse_tick |-> time_clock_tick)
        else $error("pulse without clock edge");
    a_tick_needs_ref: assert property (
        fractional_divider_output == '0 |=> !time_clock_tick)
        else $error("clock edge without reference");
endmodule : tod_properties

bind time_of_day_counter tod_properties #(
    .NUM_SOURCES(NUM_SOURCES),
    .ADDR_W(ADDR_W)
) u_props (
    .sys_clk, .nrst, .fractional_divider_output, .time_clock_tick,
    .time_pulse_tick, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp
);

`default_nettype wire

// file: time_of_day_counter_tb.sv
// self-checking bench for the time-of-day counter over AXI4-Lite
// assumes tod_pkg and the checker are compiled before this file
`default_nettype none

module time_of_day_counter_tb;
    import tod_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  refs = 3'h0;
    logic [1:0]  sel = 2'h0;
    logic        tog = 1'b0;
    logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        time_clock_tick, time_pulse_tick;
    int          num_errors = 0;
    int          total_checks = 0;
    integer      seed = 32'hf370b8c2;

    time_of_day_counter uut (
        .sys_clk, .nrst, .fractional_divider_output(refs), .time_clock_tick,
        .time_pulse_tick, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1)
    );

    // clock of 50 ns
    always #25 sys_clk = ~sys_clk;

    // selected reference ticks every other cycle, the others are noise
    always @(posedge sys_clk) begin
        tog  <= ~tog;
        refs <= (3'($random(seed)) & ~(3'h1 << sel)) | ({2'h0, tog} << sel);
    end

    task automatic check(input string what, input logic [63:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic wr(input logic [13:0] idx, input logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 200);
        r = s_axi_bresp;
        if (n >= 200) begin
            check("write timeout", 1, 0);
            test_done();
        end
    endtask : wr

    task automatic rd(input logic [13:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        n = 0;
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 200);
        d = s_axi_rdata;
        r = s_axi_rresp;
        if (n >= 200) begin
            check("read timeout", 1, 0);
            test_done();
        end
    endtask : rd

    // cycles until the next clock (pl=0) or pulse (pl=1) tick
    task automatic wait_tick(input bit pl, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(pl ? time_pulse_tick : time_clock_tick) && n < 3000);
        if (n >= 3000) begin
            check("tick timeout", 1, 0);
            test_done();
        end
    endtask : wait_tick

    function automatic int exp_period(int d, int p, bit pl);
        return 2 * (d + 1) * (pl ? p + 1 : 1);
    endfunction : exp_period

    function automatic logic pair_ok(logic [95:0] s, logic [51:0] t,
                                     logic [30:0] pp);
        logic [51:0] dc;
        logic [30:0] dp;
        dc = s[82:31] - t;
        dp = s[30:0] - pp;
        return dp < 31'd64 && dc - 52'(dp) * 4 <= 52'd3;
    endfunction : pair_ok

    task automatic load(input logic [51:0] t, input logic [30:0] pp,
                        input logic [1:0] arm);
        logic [1:0]  r;
        logic [31:0] v;
        int          n;
        wr(IDX_PRELOAD_W0, {t[0], pp}, r);
        wr(IDX_PRELOAD_W1, t[32:1], r);
        wr(IDX_PRELOAD_W2, {13'h0, t[51:33]}, r);
        wr(IDX_ARM, {30'h0, arm}, r);
        wr(IDX_TRIGGER, 32'h1, r);
        wait_tick(1, n);
        wait_tick(1, n);
        rd(IDX_TRIGGER, v, r);
        check("pending", v, 0);
    endtask : load

    task automatic snap(output logic [95:0] s);
        logic [31:0] v, a0, a1, w0, w1, w2;
        logic [1:0]  r;
        rd(IDX_SNAP_REQ, v, r);
        check("snap flag", v, 0);
        rd(IDX_READBACK_W0, a0, r);
        rd(IDX_READBACK_W1, a1, r);
        repeat (60) @(posedge sys_clk);
        rd(IDX_READBACK_W0, w0, r);
        rd(IDX_READBACK_W1, w1, r);
        rd(IDX_READBACK_W2, w2, r);
        check("frozen", {a1, a0}, {w1, w0});
        s = {w2, w1, w0};
    endtask : snap

    logic [13:0] rw_idx [4] = '{IDX_CLK_DIV, IDX_PULSE_DIV, IDX_ENABLE,
                                IDX_ARM};

    // main sequence
    initial begin
        logic [31:0] v, d;
        logic [1:0]  r;
        logic [95:0] s;
        logic [51:0] t0;
        logic [30:0] p0;
        int          n;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        foreach (rw_idx[i]) begin
            rd(rw_idx[i], v, r);
            check("reset value", v, 0);
        end
        rd(14'h0a30, v, r);
        check("unmapped", {r, v}, {RESP_SLVERR, 32'h0});
        wr(IDX_READBACK_W0, 32'h1, r);
        check("ro write", r, RESP_SLVERR);
        $display("test registers done");
        for (int k = 0; k < 4; k++) begin
            d = (k == 3) ? 63 : $random(seed) & 7;
            sel <= 2'(k % 3);
            wr(IDX_REF_SELECT, k % 3, r);
            wr(IDX_CLK_DIV, d, r);
            wr(IDX_PULSE_DIV, k, r);
            wr(IDX_ENABLE, 32'h1, r);
            rd(IDX_CLK_DIV, v, r);
            check("clk div", v, d);
            repeat (3) wait_tick(0, n);
            check("clock period", n, exp_period(d, k, 0));
            repeat (3) wait_tick(1, n);
            check("pulse period", n, exp_period(d, k, 1));
        end
        $display("test rates done");
        wr(IDX_ENABLE, 32'h0, r);
        repeat (2) @(posedge sys_clk);
        n = 0;
        repeat (300) @(posedge sys_clk) n += (time_clock_tick === 1'b1);
        check("ticks while off", n, 0);
        wr(IDX_REF_SELECT, 32'h3, r);
        wr(IDX_ENABLE, 32'h1, r);
        repeat (2) @(posedge sys_clk);
        n = 0;
        repeat (300) @(posedge sys_clk) n += (time_clock_tick === 1'b1);
        check("ticks unselected", n, 0);
        wr(IDX_REF_SELECT, 32'h0, r);
        wr(IDX_CLK_DIV, 32'h0, r);
        wr(IDX_ENABLE, 32'h1, r);
        t0 = 52'({$random(seed), $random(seed)});
        p0 = 31'($random(seed));
        load(t0, p0, 2'b11);
        snap(s);
        check("pair", pair_ok(s, t0, p0), 1);
        repeat (40) @(posedge sys_clk);
        rd(IDX_READBACK_W0, v, r);
        check("refresh", v != s[31:0], 1);
        load(t0 ^ 52'h8000000000000, p0 + 31'h1000, 2'b01);
        snap(s);
        check("tclk kept", s[82:31] - t0 < 52'd1000, 1);
        check("tpulse loaded",
              s[30:0] - (p0 + 31'h1000) < 31'd64, 1);
        $display("test preload done");
        test_done();
    end
endmodule : time_of_day_counter_tb

`default_nettype wire
